// ---- logic/blq_regs.vh ----
// register offsets, fields and reset values for the bulk list and done queue pointers
`ifndef BLQ_REGS_VH
`define BLQ_REGS_VH
`define BLQ_OFS_BULK_HEAD 8'h28
`define BLQ_OFS_BULK_CURRENT 8'h2c
`define BLQ_OFS_DONE_HEAD 8'h30
`define BLQ_PTR_RESET 32'h00000000
`define BLQ_PTR_MASK 32'hfffffff0
`define BLQ_LIST_FILLED_BIT 1
`define BLQ_BULK_ENABLE_BIT 5
`endif

// ---- logic/blq_ptr_reg.v ----
// one 32-bit descriptor pointer register with reserved low nibble
`timescale 1ns/10ps
`default_nettype none
`include "blq_regs.vh"
module blq_ptr_reg (
    input wire core_clk, // clock
    input wire rst_n, // async reset, active low
    input wire load, // take new value
    input wire [31:0] value, // new value
    output reg [31:0] q // held pointer
);
    // reserved low bits always hold the reset value
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= `BLQ_PTR_RESET;
        end else if (load) begin
            q <= value & `BLQ_PTR_MASK;
        end
    end
endmodule
`default_nettype wire

// ---- logic/blq_pointer_bank.v ----
// bulk list current pointer and done queue head register bank
`timescale 1ns/10ps
`default_nettype none
`include "blq_regs.vh"
module blq_pointer_bank (
    input wire core_clk, // clock
    input wire rst_n, // async reset, active low
    input wire regWrite, // register write strobe
    input wire regRead, // register read strobe
    input wire [7:0] regAddr, // register offset
    input wire [31:0] regWdata, // write data
    output reg [31:0] regRdata, // read data
    input wire [31:0] controlRegister, // control register contents
    input wire [31:0] bulkHeadPointer, // bulk head pointer register
    input wire listFilledFlag, // list-filled flag from command status
    output wire listFilledClear, // pulse clearing the list-filled flag
    input wire endpointServed, // pulse: current endpoint descriptor served
    input wire [31:0] endpointNextPointer, // next pointer of served descriptor
    input wire listEnd, // pulse: traversal reached list end
    input wire transferCompleted, // pulse: transfer descriptor completed
    input wire [31:0] transferAddress, // address of completed descriptor
    output reg [31:0] nextDescriptorField, // value to write into next field
    output reg nextFieldWrite, // pulse: write next field
    input wire commAreaWrite, // pulse: copy done head to shared area
    output reg [31:0] commAreaDoneHead, // value copied to shared area
    output reg commAreaValid, // pulse: copy value valid
    output wire bulkListEnd // current pointer is zero
);
    ////////////////////////////////////////////////////////////////////
    // held pointer values
    wire [31:0] bulkCurrent;
    wire [31:0] doneHead;

    // control and address decode
    wire bulkEnable;
    wire bulkAddrHit;
    wire doneAddrHit;

    // register access strobes
    wire hostBulkWrite;
    wire hostDoneWrite;
    wire bulkReadHit;
    wire doneReadHit;

    // bulk pointer update sources, highest priority first
    wire bulkReloadHit;
    wire bulkStepHit;
    wire bulkHostHit;

    // done head update sources, highest priority first
    wire doneChainHit;
    wire doneFlushHit;
    wire doneHostHit;

    // next values for the two pointer registers
    reg bulkLoad;
    reg [31:0] next_bulk;
    reg doneLoad;
    reg [31:0] next_done;

    // next values for the registered outputs
    reg [31:0] next_rdata;
    reg [31:0] next_field;
    reg next_fieldWrite;
    reg [31:0] next_commHead;
    reg next_commValid;

    ////////////////////////////////////////////////////////////////////
    // register decode; bulk pointer writes locked while the list runs
    assign bulkEnable = controlRegister[`BLQ_BULK_ENABLE_BIT];
    assign bulkAddrHit = (regAddr == `BLQ_OFS_BULK_CURRENT);
    assign doneAddrHit = (regAddr == `BLQ_OFS_DONE_HEAD);
    assign hostBulkWrite = regWrite && bulkAddrHit && !bulkEnable;
    assign hostDoneWrite = regWrite && doneAddrHit;

    // reads sample the live pointers on the strobe edge
    assign bulkReadHit = regRead && bulkAddrHit;
    assign doneReadHit = regRead && doneAddrHit;

    // end of list is a zero pointer, the same as the reset value
    assign bulkListEnd = (bulkCurrent == `BLQ_PTR_RESET);

    ////////////////////////////////////////////////////////////////////
    // bulk update sources; list end outranks a served descriptor
    assign bulkReloadHit = listEnd && listFilledFlag;
    assign bulkStepHit = endpointServed && !listEnd;

    // host writes land only when no list event claims the cycle
    assign bulkHostHit = hostBulkWrite && !listEnd && !endpointServed;

    // flag clear goes out in the same cycle as the reload
    assign listFilledClear = bulkReloadHit;

    // bulk pointer next value; held across frames, never reset per frame
    always @* begin
        bulkLoad = 1'b0;
        next_bulk = bulkCurrent;
        if (bulkReloadHit) begin
            bulkLoad = 1'b1;
            next_bulk = bulkHeadPointer;
        end else if (bulkStepHit) begin
            bulkLoad = 1'b1;
            next_bulk = endpointNextPointer;
        end else if (bulkHostHit) begin
            bulkLoad = 1'b1;
            next_bulk = regWdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // done head update sources; a completion outranks a flush
    assign doneChainHit = transferCompleted;
    assign doneFlushHit = commAreaWrite && !transferCompleted;
    assign doneHostHit = hostDoneWrite && !transferCompleted && !commAreaWrite;

    // done head next value; a flush empties the queue head
    always @* begin
        doneLoad = 1'b0;
        next_done = doneHead;
        if (doneChainHit) begin
            doneLoad = 1'b1;
            next_done = transferAddress;
        end else if (doneFlushHit) begin
            doneLoad = 1'b1;
            next_done = `BLQ_PTR_RESET;
        end else if (doneHostHit) begin
            doneLoad = 1'b1;
            next_done = regWdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pointer storage; reserved low bits are forced to zero inside
    blq_ptr_reg bulkReg (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load(bulkLoad),
        .value(next_bulk),
        .q(bulkCurrent)
    );

    blq_ptr_reg doneReg (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load(doneLoad),
        .value(next_done),
        .q(doneHead)
    );

    ////////////////////////////////////////////////////////////////////
    // completion chaining: the old head goes out with the write pulse
    always @* begin
        next_fieldWrite = doneChainHit;
        next_field = nextDescriptorField;
        if (doneChainHit) begin
            next_field = doneHead;
        end
    end

    // shared area copy: the head seen before the flush clears it
    always @* begin
        next_commValid = doneFlushHit;
        next_commHead = commAreaDoneHead;
        if (doneFlushHit) begin
            next_commHead = doneHead;
        end
    end

    // chaining outputs
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nextDescriptorField <= `BLQ_PTR_RESET;
            nextFieldWrite <= 1'b0;
        end else begin
            nextDescriptorField <= next_field;
            nextFieldWrite <= next_fieldWrite;
        end
    end

    // shared area copy outputs
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            commAreaDoneHead <= `BLQ_PTR_RESET;
            commAreaValid <= 1'b0;
        end else begin
            commAreaDoneHead <= next_commHead;
            commAreaValid <= next_commValid;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data select; unmapped offsets read zero
    always @* begin
        next_rdata = regRdata;
        if (bulkReadHit) begin
            next_rdata = bulkCurrent;
        end else if (doneReadHit) begin
            next_rdata = doneHead;
        end else if (regRead) begin
            next_rdata = `BLQ_PTR_RESET;
        end
    end

    // read data register, changes only on a read strobe
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= `BLQ_PTR_RESET;
        end else begin
            regRdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// ---- tb/blq_host_model.sv ----
// host side model holding the list-filled flag
`timescale 1ns/10ps
`default_nettype none
module blq_host_model (
    input wire logic core_clk, // clock
    input wire logic rst_n, // async reset, active low
    input wire logic setFlag, // driver sets the flag
    input wire logic listFilledClear, // device clears the flag
    output logic listFilledFlag // flag level
);
    // set by the driver, cleared only by the device
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) listFilledFlag <= 1'b0;
        else if (setFlag) listFilledFlag <= 1'b1;
        else if (listFilledClear) listFilledFlag <= 1'b0;
    end
endmodule
`default_nettype wire

// ---- tb/blq_chk.sv ----
// port assertions for the pointer bank
`timescale 1ns/10ps
`default_nettype none
module blq_chk (
    input wire logic core_clk, // clock
    input wire logic rst_n, // async reset, active low
    input wire logic listFilledFlag, // list-filled flag
    input wire logic listFilledClear, // flag clear pulse
    input wire logic endpointServed, // descriptor served pulse
    input wire logic listEnd, // list end pulse
    input wire logic transferCompleted, // completion pulse
    input wire logic nextFieldWrite, // next field write pulse
    input wire logic commAreaWrite, // copy request
    input wire logic commAreaValid, // copy valid pulse
    input wire logic bulkListEnd, // current pointer is zero
    input wire logic [31:0] bulkHeadPointer, // reload source
    input wire logic [31:0] endpointNextPointer, // next pointer of served descriptor
    input wire logic [31:0] transferAddress, // completed descriptor address
    input wire logic [31:0] nextDescriptorField, // old done head
    input wire logic [31:0] commAreaDoneHead // copied done head
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_flag_clr: assert property (listFilledClear == (listEnd && listFilledFlag))
        else $error("bad flag clear");
    a_head_load: assert property (listEnd && listFilledFlag && |bulkHeadPointer[31:4]
        |=> !bulkListEnd) else $error("no reload");
    a_endpoint_step: assert property (endpointServed && !listEnd
        |=> bulkListEnd == ($past(endpointNextPointer) < 32'h10)) else $error("no step");
    a_end_keep: assert property (listEnd && !listFilledFlag && !endpointServed
        |=> $stable(bulkListEnd)) else $error("end moved");
    a_xfer_pulse: assert property (transferCompleted |=> nextFieldWrite)
        else $error("no pulse");
    a_xfer_chain: assert property (transferCompleted ##1 transferCompleted
        |=> nextDescriptorField == ($past(transferAddress, 2) & 32'hfffffff0))
        else $error("chain");
    a_field_hold: assert property (!transferCompleted |=> $stable(nextDescriptorField))
        else $error("field moved");
    a_copy_pulse: assert property (commAreaWrite && !transferCompleted |=> commAreaValid)
        else $error("no copy");
    a_copy_hold: assert property (!(commAreaWrite && !transferCompleted)
        |=> $stable(commAreaDoneHead)) else $error("copy moved");
    a_copy_zero: assert property (commAreaWrite && !transferCompleted ##1 transferCompleted
        |=> nextDescriptorField == 32'h0) else $error("head kept");
endmodule
bind blq_pointer_bank blq_chk i_blq_chk (.core_clk, .rst_n, .listFilledFlag, .listFilledClear,
    .endpointServed, .listEnd, .transferCompleted, .nextFieldWrite, .commAreaWrite,
    .commAreaValid, .bulkListEnd, .bulkHeadPointer, .endpointNextPointer, .transferAddress,
    .nextDescriptorField, .commAreaDoneHead);
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the pointer bank
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic core_clk, rst_n, regWrite, regRead, endpointServed, listEnd, transferCompleted;
    logic commAreaWrite, setFlag, listFilledFlag, listFilledClear, nextFieldWrite, commAreaValid;
    logic bulkListEnd;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, controlRegister, bulkHeadPointer, endpointNextPointer;
    logic [31:0] transferAddress, nextDescriptorField, commAreaDoneHead;
    int error_cnt = 0;
    int checks_done = 0;
    blq_pointer_bank i_blq_pointer_bank (.core_clk, .rst_n, .regWrite, .regRead, .regAddr,
        .regWdata, .regRdata, .controlRegister, .bulkHeadPointer, .listFilledFlag,
        .listFilledClear, .endpointServed, .endpointNextPointer, .listEnd, .transferCompleted,
        .transferAddress, .nextDescriptorField, .nextFieldWrite, .commAreaWrite,
        .commAreaDoneHead, .commAreaValid, .bulkListEnd);
    blq_host_model i_blq_host_model (.core_clk, .rst_n, .setFlag, .listFilledClear,
        .listFilledFlag);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge core_clk);
        #1;
    endtask
    // one cycle of an event input; strobes stay up until the next task drops them
    task automatic ev(input int k, input logic [31:0] v);
        {regWrite, regRead} = 2'b00;
        {endpointServed, listEnd, transferCompleted, commAreaWrite} = 4'h8 >> k;
        endpointNextPointer = v;
        transferAddress = v;
        step;
    endtask
    // quiet cycle with every strobe low
    task automatic idle;
        {regWrite, regRead} = 2'b00;
        {endpointServed, listEnd, transferCompleted, commAreaWrite} = 4'h0;
        step;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        {endpointServed, listEnd, transferCompleted, commAreaWrite} = 4'h0;
        {regWrite, regRead, regAddr, regWdata} = {2'b10, a, d};
        step;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        {endpointServed, listEnd, transferCompleted, commAreaWrite} = 4'h0;
        {regWrite, regRead, regAddr} = {2'b01, a};
        step;
        chk(regRdata, exp);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // hang guard
    initial begin
        #100000;
        error_cnt++;
        test_done;
    end
    // main sequence
    initial begin
        {regWrite, regRead, endpointServed, listEnd, transferCompleted, commAreaWrite} = 6'h0;
        setFlag = 1'b0;
        {regAddr, regWdata, controlRegister, endpointNextPointer, transferAddress} = 136'h0;
        bulkHeadPointer = 32'h2000;
        rst_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #1 rst_n = 1'b1;
        rd(8'h2c, 32'h0);
        chk({31'h0, bulkListEnd}, 32'h1);
        wr(8'h2c, 32'h1234567f);
        rd(8'h2c, 32'h12345670);
        controlRegister = 32'h20;
        wr(8'h2c, 32'hdeadbee0);
        rd(8'h2c, 32'h12345670);
        ev(0, 32'h1000);
        rd(8'h2c, 32'h1000);
        chk({31'h0, bulkListEnd}, 32'h0);
        ev(1, 32'h0);
        rd(8'h2c, 32'h1000);
        ev(0, 32'h0);
        rd(8'h2c, 32'h0);
        setFlag = 1'b1;
        idle;
        setFlag = 1'b0;
        ev(1, 32'h0);
        rd(8'h2c, 32'h2000);
        chk({31'h0, listFilledFlag}, 32'h0);
        ev(2, 32'h105);
        chk({31'h0, nextFieldWrite}, 32'h1);
        ev(2, 32'h200);
        chk(nextDescriptorField, 32'h100);
        rd(8'h30, 32'h200);
        ev(3, 32'h0);
        chk({31'h0, commAreaValid}, 32'h1);
        ev(2, 32'h300);
        chk(commAreaDoneHead, 32'h200);
        chk(nextDescriptorField, 32'h0);
        chk({31'h0, commAreaValid}, 32'h0);
        rd(8'h30, 32'h300);
        ev(3, 32'h0);
        rd(8'h30, 32'h0);
        wr(8'h30, 32'h440);
        rd(8'h30, 32'h440);
        rd(8'h44, 32'h0);
        test_done;
    end
endmodule
`default_nettype wire
